// ---- logic/ssp_pkg.sv ----
package ssp_pkg;
  // Register indexes on the plain port
  localparam logic [1:0] ADDR_STAT = 2'h0;
  localparam logic [1:0] ADDR_BUF = 2'h1;
  localparam logic [1:0] ADDR_CON1 = 2'h2;
  localparam logic [1:0] ADDR_CON2 = 2'h3;
  // Status/control fields
  localparam int STAT_EN = 15;
  localparam int STAT_SIDL = 13;
  localparam int STAT_BEC_LO = 8;
  localparam int STAT_SHIFT_REG_EMPTY = 7;
  localparam int STAT_ROV = 6;
  localparam int STAT_RXMPT = 5;
  localparam int STAT_INTERRUPT_CONDITION_SELECT_LO = 2;
  localparam int STAT_TBF = 1;
  localparam int STAT_RBF = 0;
  // Control 1 fields
  localparam int CON1_DISSDO = 11;
  localparam int CON1_WORD_WIDTH_SELECT = 10;
  localparam int CON1_SMP = 9;
  localparam int CON1_CKE = 8;
  localparam int CON1_SLAVE_SELECT_USE = 7;
  localparam int CON1_CKP = 6;
  localparam int CON1_MASTER_SELECT = 5;
  localparam int CON1_SECONDARY_PRESCALE_LO = 2;
  localparam int CON1_PRIMARY_PRESCALE_LO = 0;
  // Control 2 fields
  localparam int CON2_FRAMED_ENABLE = 15;
  localparam int CON2_FSD = 14;
  localparam int CON2_FRAME_PULSE_POLARITY = 13;
  localparam int CON2_FRAME_PULSE_EDGE = 1;
  localparam int CON2_BEN = 0;
  localparam logic [15:0] RESET_VAL = 16'h0000;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] FIFO_FULL = 4'h8;
  localparam logic [3:0] FIFO_3Q = 4'h6;
  localparam logic [4:0] BITS16 = 5'h10;
  localparam logic [4:0] BITS8 = 5'h08;
  // Master half bit in clocks, less one; the three-flop input path needs five
  localparam logic [7:0] HALF_BIT_LAST = 8'h05;
  // Event select codes
  localparam logic [2:0] SEL_TX_FULL = 3'h7;
  localparam logic [2:0] SEL_TX_EMPTY = 3'h6;
  localparam logic [2:0] SEL_TX_DONE = 3'h5;
  localparam logic [2:0] SEL_TX_ONE = 3'h4;
  localparam logic [2:0] SEL_RX_FULL = 3'h3;
  localparam logic [2:0] SEL_RX_3Q = 3'h2;
  localparam logic [2:0] SEL_RX_AVAIL = 3'h1;
  localparam logic [2:0] SEL_RX_READ = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SYNC = 2'b01,
    ST_SHIFT = 2'b10
  } ssp_state_e;

  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic sdo_o;
    logic sdo_oe;
    logic ss_o;
    logic ss_oe;
  } ssp_pins_s;
endpackage

// ---- logic/ssp_top.sv ----
// The strobed register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// (RULE1) Four, three or two pin use; three-pin ignores the select pin.
// (RULE2) Two-pin use drives no data out and ignores the select pin.
// (RULE3) Eight-entry FIFO per direction plus DMA request outputs.
// (RULE4) FIFO can be disabled, giving single-buffer behaviour.
// (RULE5) Enable bit gives the pins to the port; clear disables.
// (RULE6) Idle-stop bit halts the module during device idle.
// (RULE7) Element count: pending transmits as master, unread receives as slave.
// (RULE8) Shift-register-empty bit reads one when nothing is shifting; here it reads zero while the port is disabled.
// (RULE9) Overflow set when new data arrives unread; new data dropped; software clears.
// (RULE10) Receive-FIFO-empty bit reads one when no entries held; here it reads zero while the port is disabled.
// (RULE11) Event select codes seven to four pick transmit conditions.
// (RULE12) Event select codes three to zero pick receive conditions.
// (RULE13) Standard: transmit full set on write, cleared on load to shifter.
// (RULE14) Enhanced: transmit full set when last slot filled, cleared when free.
// (RULE15) Standard: receive full set on capture, cleared on software read.
// (RULE16) Enhanced: receive full set when last slot filled, cleared when free.
// (RULE17) Framed mode runs the clock continuously; a sync pulse starts frames.
// (RULE18) Software never enables framed mode and select use together.
// (RULE19) Software sets sample phase only with or after master enable.
// (RULE20) Written word moves to the shifter; buffer empty once sending starts.
// (RULE21) Software preloads transmit data before a master transaction.
// (RULE22) Word width bit chooses sixteen or eight bit transfers.
// (RULE23) Clock polarity sets idle level; edge bit sets data change edge.
// (RULE24) Sync pulse coincides with or precedes first bit; polarity selectable.
// (RULE25) Software never sets both prescalers to one to one.
// (RULE26) Full duplex, one bit each way per clock, MSB first.
module ssp_top (
  input wire logic clock, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic [1:0] addr, // Register index
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [15:0] rdata, // Read data
  input wire logic device_idle, // Device idle mode
  input wire logic serial_data_in, // Data in pin
  input wire logic shift_clock_pin_i, // Clock pin in
  input wire logic select_frame_pin_i, // Select/frame pin in
  output ssp_pkg::ssp_pins_s pins, // Pin drives
  output logic event_o, // Selected buffer event
  output logic dma_rx_req, // Receive data waiting
  output logic dma_tx_req // Transmit room free
);
  logic [15:0] con1_r, con2_r;
  logic en_r, sidl_r, rov_r;
  logic [2:0] interrupt_condition_select_r;
  logic [15:0] txf_r [8];
  logic [15:0] rxf_r [8];
  logic [3:0] txc_r, rxc_r;
  logic [2:0] txw_r, txrd_r, rxw_r, rxrd_r;
  logic [15:0] sr_r, rin_r;
  logic [4:0] bits_r;
  logic [7:0] div_r;
  logic sck_r;
  ssp_pkg::ssp_state_e st_r;
  logic [2:0] sck_s_r, sdi_s_r, ss_s_r;
  ssp_pkg::ssp_pins_s pins_r;
  logic [15:0] rdata_r;
  logic ev_r, dmr_r, dmt_r;

  logic ben, mst, m16, clock_idle_polarity, cke, frm, slave_select_use, fpol, fdly, dissdo, run;
  assign ben = con2_r[ssp_pkg::CON2_BEN];
  assign mst = con1_r[ssp_pkg::CON1_MASTER_SELECT];
  assign m16 = con1_r[ssp_pkg::CON1_WORD_WIDTH_SELECT];
  assign clock_idle_polarity = con1_r[ssp_pkg::CON1_CKP];
  assign cke = con1_r[ssp_pkg::CON1_CKE];
  assign frm = con2_r[ssp_pkg::CON2_FRAMED_ENABLE];
  assign slave_select_use = con1_r[ssp_pkg::CON1_SLAVE_SELECT_USE];
  assign fpol = con2_r[ssp_pkg::CON2_FRAME_PULSE_POLARITY];
  assign fdly = con2_r[ssp_pkg::CON2_FRAME_PULSE_EDGE];
  assign dissdo = con1_r[ssp_pkg::CON1_DISSDO];
  // (RULE5) (RULE6) Enable and idle halt
  assign run = en_r && !(sidl_r && device_idle);

  // Capacity follows buffer mode
  function automatic logic [3:0] cap(input logic b);
    cap = b ? ssp_pkg::FIFO_FULL : 4'h1;
  endfunction

  logic [3:0] tcap;
  assign tcap = cap(ben);

  // Pin synchronisers; clock input changes once stages two and three agree
  logic sck_in, sck_prev_r, sdi_in, ss_in;
  always_ff @(posedge clock) begin
    if (reset) begin
      sck_s_r <= 3'h0;
      sdi_s_r <= 3'h0;
      ss_s_r <= 3'h7;
      sck_prev_r <= 1'b0;
    end else begin
      sck_s_r <= {sck_s_r[1:0], shift_clock_pin_i};
      sdi_s_r <= {sdi_s_r[1:0], serial_data_in};
      ss_s_r <= {ss_s_r[1:0], select_frame_pin_i};
      if (sck_s_r[1] == sck_s_r[2]) begin
        sck_prev_r <= sck_s_r[2];
      end
    end
  end
  assign sck_in = (sck_s_r[1] == sck_s_r[2]) ? sck_s_r[2] : sck_prev_r;
  assign sdi_in = sdi_s_r[2];
  assign ss_in = ss_s_r[2];

  // Bus strobes
  logic wr_buf, rd_buf;
  assign wr_buf = wr && addr == ssp_pkg::ADDR_BUF;
  assign rd_buf = rd && addr == ssp_pkg::ADDR_BUF;

  // Serial engine events
  logic load, done, lead, trail, sample_edge, shift_edge, frame_go, slave_sel;
  logic [3:0] rcap;
  assign rcap = cap(ben);
  logic [4:0] nbits;
  // (RULE22) Word width
  assign nbits = m16 ? ssp_pkg::BITS16 : ssp_pkg::BITS8;

  // Master divider; slave follows pin edges
  logic m_tick;
  always_ff @(posedge clock) begin
    if (reset || !run || !mst) begin
      div_r <= 8'h00;
    end else begin
      div_r <= (div_r == ssp_kdiv()) ? 8'h00 : div_r + 8'h01;
    end
  end
  function automatic logic [7:0] ssp_kdiv();
    ssp_kdiv = ssp_pkg::HALF_BIT_LAST;
  endfunction
  assign m_tick = mst && div_r == ssp_kdiv();

  // Leading edge is idle-to-active; trailing is active-to-idle
  logic sck_act;
  // (RULE23) Clock polarity
  assign sck_act = mst ? sck_r : (sck_in ^ clock_idle_polarity);
  logic sck_act_prev_r;
  always_ff @(posedge clock) begin
    if (reset) begin
      sck_act_prev_r <= 1'b0;
    end else begin
      sck_act_prev_r <= sck_in ^ clock_idle_polarity;
    end
  end
  assign lead = mst ? (m_tick && !sck_act) : (sck_act && !sck_act_prev_r);
  assign trail = mst ? (m_tick && sck_act) : (!sck_act && sck_act_prev_r);
  // (RULE23) Data change edge; framed mode forces trailing sample
  assign shift_edge = (cke && !frm) ? trail : lead;
  assign sample_edge = (cke && !frm) ? lead : trail;
  // (RULE1) (RULE2) Select pin used only with select or framed mode
  assign slave_sel = !slave_select_use || ss_in == 1'b0;
  assign frame_go = frm ? (mst ? txc_r != 4'h0 : (ss_in == fpol) && lead)
                        : (mst ? txc_r != 4'h0 && !sck_r : slave_sel);
  assign load = run && st_r == ssp_pkg::ST_IDLE && frame_go && (mst ? 1'b1 : lead || frm);
  assign done = run && st_r == ssp_pkg::ST_SHIFT && sample_edge && bits_r == 5'h01;
  logic [15:0] head_word;
  assign head_word = txc_r != 4'h0 ? txf_r[txrd_r] : 16'hffff;

  // (RULE26) Shift engine, MSB first, full duplex
  always_ff @(posedge clock) begin
    if (reset || !en_r) begin
      st_r <= ssp_pkg::ST_IDLE;
      sr_r <= ssp_pkg::RESET_VAL;
      bits_r <= 5'h00;
      sck_r <= 1'b0;
    end else if (run) begin
      case (st_r)
        ssp_pkg::ST_IDLE: begin
          // Master lets a last active half bit run out before idling
          sck_r <= (mst && (frm || sck_r)) ? sck_r ^ m_tick : 1'b0;
          // Slave shows its next word before the first clock edge
          if (!mst || load) begin
            sr_r <= head_word;
          end
          if (load) begin
            // (RULE20) Word moves into shifter
            bits_r <= nbits;
            // Slave first edge may also be its sample edge
            if (!mst && sample_edge) begin
              rin_r <= {rin_r[14:0], sdi_in};
              bits_r <= nbits - 5'h01;
            end
            // (RULE24) Pulse precedes or coincides with first bit
            st_r <= (frm && !fdly) ? ssp_pkg::ST_SYNC : ssp_pkg::ST_SHIFT;
          end
        end
        ssp_pkg::ST_SYNC: begin
          if (mst) begin
            sck_r <= sck_r ^ m_tick;
          end
          if (trail) begin
            st_r <= ssp_pkg::ST_SHIFT;
          end
        end
        ssp_pkg::ST_SHIFT: begin
          if (mst) begin
            sck_r <= sck_r ^ m_tick;
          end
          if (sample_edge) begin
            rin_r <= {rin_r[14:0], sdi_in};
            bits_r <= bits_r - 5'h01;
          end
          if (shift_edge && bits_r != nbits) begin
            sr_r <= {sr_r[14:0], 1'b0};
          end
          if (done) begin
            st_r <= ssp_pkg::ST_IDLE;
          end
        end
        default: st_r <= ssp_pkg::ST_IDLE;
      endcase
    end
  end

  // Received word with width applied
  logic [15:0] rx_word;
  assign rx_word = m16 ? {rin_r[14:0], sdi_in} : {8'h00, rin_r[6:0], sdi_in};

  // (RULE3) (RULE4) Transmit FIFO or single buffer
  logic tx_push;
  assign tx_push = wr_buf && txc_r < tcap;
  always_ff @(posedge clock) begin
    if (reset || !en_r) begin
      txc_r <= 4'h0;
      txw_r <= 3'h0;
      txrd_r <= 3'h0;
    end else begin
      if (tx_push) begin
        txf_r[txw_r] <= wdata;
        txw_r <= ben ? txw_r + 3'h1 : 3'h0;
      end
      if (load && txc_r != 4'h0) begin
        txrd_r <= ben ? txrd_r + 3'h1 : 3'h0;
      end
      txc_r <= txc_r + {3'h0, tx_push} - {3'h0, load && txc_r != 4'h0};
    end
  end

  // (RULE9) Receive FIFO; overflow drops the new word
  logic rx_pop, rx_push, rx_ovf;
  assign rx_pop = rd_buf && rxc_r != 4'h0;
  assign rx_ovf = done && rxc_r == rcap && !rx_pop;
  assign rx_push = done && !rx_ovf;
  always_ff @(posedge clock) begin
    if (reset || !en_r) begin
      rxc_r <= 4'h0;
      rxw_r <= 3'h0;
      rxrd_r <= 3'h0;
    end else begin
      if (rx_push) begin
        rxf_r[rxw_r] <= rx_word;
        rxw_r <= ben ? rxw_r + 3'h1 : 3'h0;
      end
      if (rx_pop) begin
        rxrd_r <= ben ? rxrd_r + 3'h1 : 3'h0;
      end
      rxc_r <= rxc_r + {3'h0, rx_push} - {3'h0, rx_pop};
    end
  end

  // Control registers; overflow set wins over clear
  always_ff @(posedge clock) begin
    if (reset) begin
      en_r <= 1'b0;
      sidl_r <= 1'b0;
      interrupt_condition_select_r <= 3'h0;
      rov_r <= 1'b0;
      con1_r <= ssp_pkg::RESET_VAL;
      con2_r <= ssp_pkg::RESET_VAL;
    end else begin
      if (wr && addr == ssp_pkg::ADDR_STAT) begin
        en_r <= wdata[ssp_pkg::STAT_EN];
        sidl_r <= wdata[ssp_pkg::STAT_SIDL];
        interrupt_condition_select_r <= wdata[ssp_pkg::STAT_INTERRUPT_CONDITION_SELECT_LO +: 3];
      end
      if (wr && addr == ssp_pkg::ADDR_CON1) begin
        con1_r <= wdata;
      end
      if (wr && addr == ssp_pkg::ADDR_CON2) begin
        con2_r <= wdata;
      end
      // (RULE9) Overflow sticky
      if (rx_ovf) begin
        rov_r <= 1'b1;
      end else if (wr && addr == ssp_pkg::ADDR_STAT && !wdata[ssp_pkg::STAT_ROV]) begin
        rov_r <= 1'b0;
      end
    end
  end

  // Status image
  logic tbf, rbf, shift_reg_empty;
  // (RULE13) (RULE14) Transmit full
  assign tbf = txc_r == tcap;
  // (RULE15) (RULE16) Receive full
  assign rbf = rxc_r == rcap;
  // (RULE8) Shifter empty
  // Empty flags read zero while off, as at power-on
  assign shift_reg_empty = en_r && st_r == ssp_pkg::ST_IDLE;
  logic [15:0] stat;
  always_comb begin
    stat = ssp_pkg::RESET_VAL;
    stat[ssp_pkg::STAT_EN] = en_r;
    stat[ssp_pkg::STAT_SIDL] = sidl_r;
    // (RULE7) Element count by role
    stat[ssp_pkg::STAT_BEC_LO +: 3] = mst ? txc_r[2:0] : rxc_r[2:0];
    stat[ssp_pkg::STAT_SHIFT_REG_EMPTY] = shift_reg_empty;
    stat[ssp_pkg::STAT_ROV] = rov_r;
    // (RULE10) Receive empty
    stat[ssp_pkg::STAT_RXMPT] = en_r && rxc_r == 4'h0;
    stat[ssp_pkg::STAT_INTERRUPT_CONDITION_SELECT_LO +: 3] = interrupt_condition_select_r;
    stat[ssp_pkg::STAT_TBF] = tbf;
    stat[ssp_pkg::STAT_RBF] = rbf;
  end

  // Read port, data in the next cycle
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_r <= ssp_pkg::RESET_VAL;
    end else if (rd) begin
      case (addr)
        ssp_pkg::ADDR_STAT: rdata_r <= stat;
        ssp_pkg::ADDR_BUF: rdata_r <= rxc_r != 4'h0 ? rxf_r[rxrd_r] : ssp_pkg::RESET_VAL;
        ssp_pkg::ADDR_CON1: rdata_r <= con1_r;
        ssp_pkg::ADDR_CON2: rdata_r <= con2_r;
        default: rdata_r <= ssp_pkg::RESET_VAL;
      endcase
    end else begin
      rdata_r <= ssp_pkg::RESET_VAL;
    end
  end

  // Buffer event select
  logic ev;
  always_comb begin
    case (interrupt_condition_select_r)
      // (RULE11) Transmit triggers
      ssp_pkg::SEL_TX_FULL: ev = tbf;
      ssp_pkg::SEL_TX_EMPTY: ev = load && txc_r == 4'h1;
      ssp_pkg::SEL_TX_DONE: ev = done && txc_r == 4'h0;
      ssp_pkg::SEL_TX_ONE: ev = load && txc_r == tcap;
      // (RULE12) Receive triggers
      ssp_pkg::SEL_RX_FULL: ev = rbf;
      ssp_pkg::SEL_RX_3Q: ev = rxc_r >= ssp_pkg::FIFO_3Q;
      ssp_pkg::SEL_RX_AVAIL: ev = rxc_r != 4'h0;
      ssp_pkg::SEL_RX_READ: ev = rx_pop && rxc_r == 4'h1;
      default: ev = 1'b0;
    endcase
  end

  // Registered outputs and pin drive
  always_ff @(posedge clock) begin
    if (reset) begin
      ev_r <= 1'b0;
      dmr_r <= 1'b0;
      dmt_r <= 1'b0;
      pins_r <= '0;
    end else begin
      ev_r <= en_r && ev;
      // (RULE3) DMA requests
      dmr_r <= en_r && rxc_r != 4'h0;
      dmt_r <= en_r && txc_r < tcap;
      // (RULE5) Pins given over only while enabled
      pins_r.sck_o <= sck_r ^ clock_idle_polarity;
      pins_r.sck_oe <= en_r && mst;
      pins_r.sdo_o <= m16 ? sr_r[15] : sr_r[7];
      // (RULE2) Data out released in two-pin use
      pins_r.sdo_oe <= en_r && !dissdo && (mst || slave_sel);
      // (RULE17) (RULE24) Master frame pulse
      pins_r.ss_o <= (frm && load && fdly) || st_r == ssp_pkg::ST_SYNC ? fpol : !fpol;
      // (RULE1) Select pin driven only in framed use with FSD clear
      pins_r.ss_oe <= en_r && frm && !con2_r[ssp_pkg::CON2_FSD];
    end
  end

  assign pins = pins_r;
  assign rdata = rdata_r;
  assign event_o = ev_r;
  assign dma_rx_req = dmr_r;
  assign dma_tx_req = dmt_r;
endmodule

// ---- test/ssp_assertions.sv ----
`timescale 1ns/1ps
module ssp_assertions (
  input wire logic clock, // Clock
  input wire logic reset, // Reset
  input wire logic [1:0] addr, // Index
  input wire logic [15:0] wdata, // Write data
  input wire logic wr, // Write
  input wire logic rd, // Read
  input wire logic [15:0] rdata, // Read data
  input wire logic device_idle, // Idle
  input wire ssp_pkg::ssp_pins_s pins // Pins
);
  logic en_r, sidl_r, mst_r, nosdo_r, ben_r;
  logic [2:0] sel_r;
  // Shadow of written fields, since the checker sees only ports
  always_ff @(posedge clock) begin
    if (reset) begin
      {en_r, sidl_r, mst_r, nosdo_r, ben_r, sel_r} <= 8'h00;
    end else if (wr) begin
      if (addr == 2'h0) {en_r, sidl_r, sel_r} <= {wdata[15], wdata[13], wdata[4:2]};
      if (addr == 2'h2) {mst_r, nosdo_r} <= {wdata[5], wdata[11]};
      if (addr == 2'h3) ben_r <= wdata[0];
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_stat_rd;
    $past(rd) && $past(addr) == 2'h0;
  endsequence
  sequence s_idle_held;
    (en_r && sidl_r && device_idle)[*3];
  endsequence
  sequence s_buf_then_stat;
    rd && addr == 2'h1 && !ben_r ##2 rd && addr == 2'h0;
  endsequence
  property p_off_pins;
    !en_r && !$past(en_r) |-> !(pins.sck_oe || pins.sdo_oe || pins.ss_oe);
  endproperty
  a_off_pins: assert property (p_off_pins)
    else $error("Pins driven while disabled");
  property p_no_sdo;
    nosdo_r && $past(nosdo_r) |-> !pins.sdo_oe;
  endproperty
  a_no_sdo: assert property (p_no_sdo)
    else $error("Data out driven in two-pin use");
  property p_slave_clk;
    !mst_r && !$past(mst_r) |-> !pins.sck_oe;
  endproperty
  a_slave_clk: assert property (p_slave_clk)
    else $error("Slave drives shift clock");
  property p_idle_halt;
    s_idle_held |-> $stable(pins.sck_o);
  endproperty
  a_idle_halt: assert property (p_idle_halt)
    else $error("Clock moved during idle stop");
  property p_stat_fields;
    s_stat_rd |-> rdata[15] == en_r && rdata[13] == sidl_r && rdata[4:2] == sel_r
      && rdata[14] == 1'b0 && rdata[12:11] == 2'h0;
  endproperty
  a_stat_fields: assert property (p_stat_fields)
    else $error("Status fields differ from written");
  property p_rx_flags;
    ben_r && $past(rd) && $past(addr) == 2'h0 |-> !(rdata[5] && rdata[0]);
  endproperty
  a_rx_flags: assert property (p_rx_flags)
    else $error("Receive empty and full together");
  property p_rbf_clear;
    s_buf_then_stat |=> !rdata[0];
  endproperty
  a_rbf_clear: assert property (p_rbf_clear)
    else $error("Receive full kept after read");
  property p_sck_rate;
    pins.sck_oe && $rose(pins.sck_o) |=> pins.sck_o;
  endproperty
  a_sck_rate: assert property (p_sck_rate)
    else $error("Shift clock high for one cycle");
endmodule
bind ssp_top ssp_assertions u_chk (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .device_idle(device_idle), .pins(pins));

// ---- test/ssp_slave_model.sv ----
`timescale 1ns/1ps
module ssp_slave_model (
  input wire logic sck, // Shift clock
  input wire logic sdo, // Data from port
  input wire logic [15:0] word, // Reply word
  input wire logic [4:0] nbits, // Word width
  output logic sdi, // Data to port
  output logic [15:0] got // Last captured
);
  logic [15:0] cap_r = 16'h0000;
  int cnt = 0;
  int idx = 0;
  initial got = 16'h0000;
  always @(posedge sck) begin
    cap_r = {cap_r[14:0], sdo};
    cnt = (cnt + 1) % nbits;
    if (cnt == 0) got = cap_r;
  end
  // change on falling; wraps to next word MSB
  always @(negedge sck) idx = cnt;
  assign sdi = word[nbits - 1 - idx];
endmodule

// ---- test/ssp_top_tb_top.sv ----
`timescale 1ns/1ps
module ssp_top_tb_top;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [1:0] addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic idle = 1'b0;
  logic sck_i = 1'b0;
  logic sdi_tb = 1'b0;
  logic slv = 1'b0;
  logic [15:0] mword = 16'h0000;
  logic [4:0] mbits = 5'h10;
  logic [15:0] rdata, mgot, s;
  logic sdi_m, ev, drx, dtx;
  ssp_pkg::ssp_pins_s pins;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  always #50 clock = ~clock;
  ssp_top uut (.clock(clock), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .device_idle(idle), .serial_data_in(slv ? sdi_tb : sdi_m),
    .shift_clock_pin_i(sck_i), .select_frame_pin_i(1'b0), .pins(pins), .event_o(ev),
    .dma_rx_req(drx), .dma_tx_req(dtx));
  // Released data line floats to its pull-up
  ssp_slave_model peer (.sck(pins.sck_o), .sdo(pins.sdo_oe ? pins.sdo_o : 1'b1),
    .word(mword), .nbits(mbits),
    .sdi(sdi_m), .got(mgot));
  task automatic check(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic report_and_stop;
    $display("Checks %0d, mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic wr_reg(input logic [1:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [1:0] a);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 s = rdata;
  endtask
  // Polls status; bounded so a stuck flag cannot hang the run
  task automatic wait_bit(input int b, input logic v);
    int n;
    n = 0;
    rd_reg(2'h0);
    while (s[b] !== v && n < 1000) begin
      rd_reg(2'h0);
      n++;
    end
    check(16'(s[b]), 16'(v));
  endtask
  task automatic t_reset;
    for (int a = 0; a < 4; a++) begin
      rd_reg(2'(a));
      check(s, ssp_pkg::RESET_VAL);
    end
  endtask
  task automatic t_master16;
    mword = 16'h3c5a;
    wr_reg(2'h2, 16'h0520);
    wr_reg(2'h0, 16'h8000);
    wr_reg(2'h1, 16'ha5c3);
    wait_bit(0, 1'b1);
    rd_reg(2'h1);
    check(s, 16'h3c5a);
    check(mgot, 16'ha5c3);
    rd_reg(2'h0);
    check(s & 16'h0003, 16'h0000);
  endtask
  task automatic t_overflow;
    mword = 16'h0f0f;
    wr_reg(2'h1, 16'h1111);
    wait_bit(0, 1'b1);
    mword = 16'hf0f0;
    wr_reg(2'h1, 16'h2222);
    wait_bit(6, 1'b1);
    rd_reg(2'h1);
    check(s, 16'h0f0f);
    wr_reg(2'h0, 16'h8000);
    rd_reg(2'h0);
    check(s & 16'h0040, 16'h0000);
  endtask
  task automatic t_enh8;
    mword = 16'h0096;
    mbits = 5'h08;
    wr_reg(2'h0, 16'h0000);
    wr_reg(2'h2, 16'h0120);
    wr_reg(2'h3, 16'h0001);
    wr_reg(2'h0, 16'h8004);
    for (int i = 0; i < 9; i++) wr_reg(2'h1, 16'h0010 + 16'(i));
    rd_reg(2'h0);
    check(s & 16'h0082, 16'h0002);
    check(16'({drx, dtx}), 16'h0000);
    wait_bit(6, 1'b1);
    check(s & 16'h0021, 16'h0001);
    check(mgot & 16'h00ff, 16'h0018);
    check(16'({drx, dtx, ev}), 16'h0007);
    for (int i = 0; i < 8; i++) begin
      rd_reg(2'h1);
      check(s, 16'h0096);
    end
    rd_reg(2'h0);
    check(s & 16'h00a1, 16'h00a0);
    check(16'({drx, dtx, ev}), 16'h0002);
  endtask
  // Bench plays master at 800 ns per bit, data moved on falling edge
  task automatic t_slave;
    logic [15:0] din;
    logic [15:0] cap;
    din = 16'hc639;
    cap = 16'h0000;
    wr_reg(2'h0, 16'h0000);
    wr_reg(2'h2, 16'h0100);
    wr_reg(2'h0, 16'h8000);
    wr_reg(2'h1, 16'h005b);
    wr_reg(2'h1, 16'h00a4);
    slv <= 1'b1;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clock);
      sdi_tb <= din[i];
      repeat (3) @(posedge clock);
      sck_i <= 1'b1;
      repeat (3) @(posedge clock);
      #1 cap = {cap[14:0], pins.sdo_o};
      @(posedge clock);
      sck_i <= 1'b0;
    end
    repeat (8) @(posedge clock);
    rd_reg(2'h0);
    check(s & 16'h0721, 16'h0200);
    rd_reg(2'h1);
    check(s, 16'h00c6);
    rd_reg(2'h1);
    check(s, 16'h0039);
    check(cap, 16'h5ba4);
    slv <= 1'b0;
  endtask
  task automatic t_pins;
    wr_reg(2'h0, 16'h0000);
    wr_reg(2'h3, 16'h0000);
    repeat (2) @(posedge clock);
    #1 check(16'({pins.sck_oe, pins.sdo_oe, pins.ss_oe}), 16'h0000);
    wr_reg(2'h2, 16'h0920);
    wr_reg(2'h0, 16'h8000);
    wr_reg(2'h1, 16'h0077);
    repeat (10) @(posedge clock);
    #1 check(16'({pins.sck_oe, pins.sdo_oe}), 16'h0002);
    wait_bit(0, 1'b1);
    check(mgot & 16'h00ff, 16'h00ff);
    rd_reg(2'h1);
    check(s, 16'h0096);
  endtask
  task automatic t_idle;
    wr_reg(2'h0, 16'h0000);
    wr_reg(2'h2, 16'h0120);
    idle <= 1'b1;
    wr_reg(2'h0, 16'ha000);
    wr_reg(2'h1, 16'h0042);
    repeat (100) @(posedge clock);
    rd_reg(2'h0);
    check(s & 16'h0001, 16'h0000);
    @(posedge clock);
    idle <= 1'b0;
    wait_bit(0, 1'b1);
    rd_reg(2'h1);
    check(s, 16'h0096);
  endtask
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    t_reset();
    t_master16();
    t_overflow();
    t_enh8();
    t_slave();
    t_pins();
    t_idle();
    report_and_stop();
  end
endmodule
